// ===== rtl/hdsq_pkg.sv
package hdsq_pkg;
    // ==========================================================
    // Data widths and iteration count
    localparam int unsigned WORD_W      = 12;
    localparam int unsigned CNT_W       = 4;
    localparam logic [3:0]  LAST_ITER   = 4'hc;
    localparam logic [11:0] WORD_RST    = 12'h000;
    localparam logic [3:0]  CNT_RST     = 4'h0;
    // ==========================================================
    // Divide subperiods
    typedef enum logic [2:0] {
        HDSQ_IDLE,
        HDSQ_ENTER,
        HDSQ_WAIT,
        HDSQ_ONCE,
        HDSQ_LOOP
    } hdsq_phase_e;
endpackage

// ===== rtl/hdsq_divider.sv
`timescale 1ns/100ps
`default_nettype none
module hdsq_divider (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        REGISTER_CLOCK_STROBE,
    input  wire logic        PULSER_PERIOD0,
    input  wire logic        PULSER_PERIOD7,
    input  wire logic        PERIOD3,
    input  wire logic        PERIOD4_MID_STROBE,
    input  wire logic        PERIOD5_MID_STROBE,
    input  wire logic        PERIOD5_END,
    input  wire logic        PERIOD6_MID_STROBE,
    input  wire logic        PERIOD6,
    input  wire logic        PERIOD7,
    input  wire logic        DIVIDE_OPCODE,
    input  wire logic        LOAD_OPERANDS,
    input  wire logic [11:0] DIVIDEND_HIGH_IN,
    input  wire logic [11:0] DIVIDEND_LOW_IN,
    input  wire logic [11:0] DIVISOR_IN,
    output logic      [11:0] QUOTIENT_ACC,
    output logic      [11:0] HIGH_ACC,
    output logic      [11:0] SAVE_ACC,
    output logic      [11:0] MEMORY_DATA_HOLDING_REG,
    output logic             CARRY_FLAG_LATCH,
    output logic             WAIT_FLAG,
    output logic             ONCE_FLAG,
    output logic             DIVISOR_LOOP_FLAG,
    output logic             DONE_LATCH,
    output logic             RECYCLE_ENABLE,
    output logic             TWELVE_COUNT_N,
    output logic             BUSY
);
    // ==========================================================
    // State
    hdsq_pkg::hdsq_phase_e  phase_q, phase_d;
    logic [11:0] j_q, j_d, k_q, k_d, r_q, r_d, s_q, s_d, mdr_q, mdr_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        ov_q, ov_d, wait_q, wait_d, once_q, once_d, rl_q, rl_d;
    logic        done_q, done_d, rec_q, rec_d, tw_n_q, tw_n_d, busy_q, busy_d;
    logic [12:0] sum;
    logic        p4, p5, p6, p5e;

    function automatic logic [12:0] add12(input logic [11:0] a, input logic [11:0] b,
                                          input logic cin);
        add12 = {1'b0, a} + {1'b0, b} + {12'h000, cin};
    endfunction

    // The period 4, 5 and 6 mid strobes and the period 5 end are gated by the register strobe
    assign p4  = PERIOD4_MID_STROBE & REGISTER_CLOCK_STROBE;
    assign p5  = PERIOD5_MID_STROBE & REGISTER_CLOCK_STROBE;
    assign p5e = PERIOD5_END & REGISTER_CLOCK_STROBE;
    assign p6  = PERIOD6_MID_STROBE & REGISTER_CLOCK_STROBE;

    // ==========================================================
    // Next-state logic
    always_comb begin
        phase_d = phase_q;
        j_d = j_q; k_d = k_q; r_d = r_q; s_d = s_q; mdr_d = mdr_q;
        cnt_d = cnt_q; ov_d = ov_q; wait_d = wait_q; once_d = once_q; rl_d = rl_q;
        done_d = done_q; rec_d = rec_q; tw_n_d = tw_n_q; busy_d = busy_q;
        sum = 13'h0000;
        if (PULSER_PERIOD7) begin
            wait_d = 1'b0;
            once_d = 1'b0;
        end
        if (PULSER_PERIOD0) begin
            rl_d = 1'b0;
        end
        case (phase_q)
            hdsq_pkg::HDSQ_IDLE: begin
                if (PERIOD3 && DIVIDE_OPCODE) begin
                    phase_d = hdsq_pkg::HDSQ_ENTER;
                    cnt_d   = hdsq_pkg::CNT_RST;
                    done_d  = 1'b0;
                    rec_d   = 1'b1;
                    tw_n_d  = 1'b1;
                    busy_d  = 1'b1;
                end
                if (LOAD_OPERANDS && !busy_q) begin
                    k_d = DIVIDEND_HIGH_IN;
                    j_d = DIVIDEND_LOW_IN;
                    r_d = DIVISOR_IN;
                end
            end
            hdsq_pkg::HDSQ_ENTER: begin
                if (p4) begin
                    ov_d = 1'b0;
                end
                sum = add12(~k_q, r_q, 1'b0);
                if (p5) begin
                    if (sum[12]) begin
                        ov_d = 1'b1;
                    end
                    s_d = k_q;
                end
                if (p5e) begin
                    wait_d  = 1'b1;
                    phase_d = hdsq_pkg::HDSQ_WAIT;
                end
            end
            hdsq_pkg::HDSQ_WAIT: begin
                if (PERIOD6 && REGISTER_CLOCK_STROBE) begin
                    done_d = 1'b1;
                    if (!ov_q) begin
                        rec_d = 1'b0;
                    end
                end
                if (!rec_q && PERIOD7 && REGISTER_CLOCK_STROBE) begin
                    ov_d    = 1'b1;
                    phase_d = hdsq_pkg::HDSQ_IDLE;
                    busy_d  = 1'b0;
                end
                // Recycled pass: the divisor still runs through the adder
                if (rec_q && p4) begin
                    ov_d = 1'b0;
                end
                sum = add12(r_q, 12'h000, 1'b0);
                if (rec_q && p5) begin
                    mdr_d = sum[11:0];
                end
                if (rec_q && p5e) begin
                    once_d  = 1'b1;
                    rl_d    = 1'b1;
                    phase_d = hdsq_pkg::HDSQ_ONCE;
                end
            end
            hdsq_pkg::HDSQ_ONCE: begin
                sum = add12(~mdr_q, 12'h000, 1'b1);
                if (p6) begin
                    mdr_d   = sum[11:0];
                    phase_d = hdsq_pkg::HDSQ_LOOP;
                end
            end
            hdsq_pkg::HDSQ_LOOP: begin
                if (p4) begin
                    ov_d  = 1'b0;
                    cnt_d = cnt_q + 4'h1;
                    {k_d, j_d} = {k_q[10:0], j_q, 1'b0};
                    if (cnt_q + 4'h1 == hdsq_pkg::LAST_ITER) begin
                        tw_n_d = 1'b0;
                        rec_d  = 1'b0;
                    end
                end
                if (PERIOD5_MID_STROBE) begin
                    sum = add12(k_q, mdr_q, 1'b0);
                end else if (ov_q) begin
                    sum = add12(j_q, 12'h000, 1'b1);
                end else begin
                    sum = add12(s_q, 12'h000, 1'b0);
                end
                if (p5) begin
                    k_d  = sum[11:0];
                    // Save takes the high word on the same strobe, so it keeps the
                    // pre-subtraction value that a failed trial restores
                    s_d  = k_q;
                    ov_d = sum[12];
                end
                if (p6) begin
                    if (ov_q) begin
                        j_d = sum[11:0];
                    end else begin
                        k_d = s_q;
                    end
                    if (!tw_n_q) begin
                        done_d  = 1'b1;
                        busy_d  = 1'b0;
                        phase_d = hdsq_pkg::HDSQ_IDLE;
                    end
                end
            end
            default: begin
                phase_d = hdsq_pkg::HDSQ_IDLE;
            end
        endcase
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            phase_q <= hdsq_pkg::HDSQ_IDLE;
            j_q     <= hdsq_pkg::WORD_RST;
            k_q     <= hdsq_pkg::WORD_RST;
            r_q     <= hdsq_pkg::WORD_RST;
            s_q     <= hdsq_pkg::WORD_RST;
            mdr_q   <= hdsq_pkg::WORD_RST;
            cnt_q   <= hdsq_pkg::CNT_RST;
            ov_q    <= 1'b0;
            wait_q  <= 1'b0;
            once_q  <= 1'b0;
            rl_q    <= 1'b0;
            done_q  <= 1'b0;
            rec_q   <= 1'b0;
            tw_n_q  <= 1'b1;
            busy_q  <= 1'b0;
        end else begin
            phase_q <= phase_d;
            j_q     <= j_d;
            k_q     <= k_d;
            r_q     <= r_d;
            s_q     <= s_d;
            mdr_q   <= mdr_d;
            cnt_q   <= cnt_d;
            ov_q    <= ov_d;
            wait_q  <= wait_d;
            once_q  <= once_d;
            rl_q    <= rl_d;
            done_q  <= done_d;
            rec_q   <= rec_d;
            tw_n_q  <= tw_n_d;
            busy_q  <= busy_d;
        end
    end

    assign QUOTIENT_ACC            = j_q;
    assign HIGH_ACC                = k_q;
    assign SAVE_ACC                = s_q;
    assign MEMORY_DATA_HOLDING_REG = mdr_q;
    assign CARRY_FLAG_LATCH        = ov_q;
    assign WAIT_FLAG               = wait_q;
    assign ONCE_FLAG               = once_q;
    assign DIVISOR_LOOP_FLAG       = rl_q;
    assign DONE_LATCH              = done_q;
    assign RECYCLE_ENABLE          = rec_q;
    assign TWELVE_COUNT_N          = tw_n_q;
    assign BUSY                    = busy_q;
endmodule
`default_nettype wire

// ===== tb/hdsq_divider_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Port checker; divisor copy follows the load that the block accepts
module hdsq_divider_asserts (
    input wire logic        CLK, ARST_N, REGISTER_CLOCK_STROBE, PULSER_PERIOD7, PERIOD3,
    input wire logic        PERIOD4_MID_STROBE, PERIOD5_MID_STROBE, PERIOD6_MID_STROBE,
    input wire logic        PERIOD7, DIVIDE_OPCODE, LOAD_OPERANDS, CARRY_FLAG_LATCH,
    input wire logic        WAIT_FLAG, ONCE_FLAG, DIVISOR_LOOP_FLAG, DONE_LATCH,
    input wire logic        RECYCLE_ENABLE, TWELVE_COUNT_N, BUSY,
    input wire logic [11:0] DIVISOR_IN, QUOTIENT_ACC, HIGH_ACC, SAVE_ACC,
    input wire logic [11:0] MEMORY_DATA_HOLDING_REG
);
    logic [11:0] r_q;
    logic [11:0] r_d;
    logic [12:0] es;
    logic [12:0] ls;
    wire         s = REGISTER_CLOCK_STROBE && BUSY;
    wire         ecy = es[12];
    wire         lcy = ls[12];
    assign es = {1'b0, ~HIGH_ACC} + {1'b0, r_q};
    assign ls = {1'b0, HIGH_ACC} + {1'b0, MEMORY_DATA_HOLDING_REG};
    always_comb begin
        r_d = (LOAD_OPERANDS && !BUSY) ? DIVISOR_IN : r_q;
    end
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r_q <= 12'h000;
        end else begin
            r_q <= r_d;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);
    // Loop period 6 is told from once period 6 by the data register already negated
    sequence s_lp6;
        s && PERIOD6_MID_STROBE && DIVISOR_LOOP_FLAG && MEMORY_DATA_HOLDING_REG != r_q;
    endsequence
    property p_start;
        REGISTER_CLOCK_STROBE && PERIOD3 && DIVIDE_OPCODE && !BUSY |=> BUSY;
    endproperty
    a_start: assert property (p_start) else $error("divide not started");
    property p_ovclr;
        s && PERIOD4_MID_STROBE |=> !CARRY_FLAG_LATCH;
    endproperty
    a_ovclr: assert property (p_ovclr) else $error("carry flag not cleared");
    property p_cmp;
        s && PERIOD5_MID_STROBE && !WAIT_FLAG |=>
            CARRY_FLAG_LATCH == $past(ecy) && SAVE_ACC == $past(HIGH_ACC);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare result wrong");
    property p_clrwo;
        REGISTER_CLOCK_STROBE && PULSER_PERIOD7 |=> !WAIT_FLAG && !ONCE_FLAG;
    endproperty
    a_clrwo: assert property (p_clrwo) else $error("wait or once not cleared");
    property p_neg;
        s && PERIOD6_MID_STROBE && ONCE_FLAG && MEMORY_DATA_HOLDING_REG == r_q |=>
            MEMORY_DATA_HOLDING_REG == -r_q;
    endproperty
    a_neg: assert property (p_neg) else $error("divisor not negated");
    property p_lsum;
        s && PERIOD5_MID_STROBE && DIVISOR_LOOP_FLAG |=> CARRY_FLAG_LATCH == $past(lcy)
            && HIGH_ACC == $past(HIGH_ACC) + $past(MEMORY_DATA_HOLDING_REG);
    endproperty
    a_lsum: assert property (p_lsum) else $error("loop sum wrong");
    property p_loop;
        s_lp6 |=> (CARRY_FLAG_LATCH ? QUOTIENT_ACC == $past(QUOTIENT_ACC) + 12'h001
            : HIGH_ACC == $past(HIGH_ACC) + r_q);
    endproperty
    a_loop: assert property (p_loop) else $error("increment or restore wrong");
    property p_end;
        s && PERIOD6_MID_STROBE && !TWELVE_COUNT_N |=> !BUSY && DONE_LATCH;
    endproperty
    a_end: assert property (p_end) else $error("divide did not end");
    property p_exit;
        s && PERIOD7 && !RECYCLE_ENABLE |=> CARRY_FLAG_LATCH && !BUSY;
    endproperty
    a_exit: assert property (p_exit) else $error("early exit wrong");
endmodule
bind hdsq_divider hdsq_divider_asserts u_chk (.*);
`default_nettype wire

// ===== tb/hdsq_pulser.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================
// Pulser model: one strobe per step, two idle cycles between steps
module hdsq_pulser (
    input  wire logic       CLK,
    input  wire logic       RECYCLE_ENABLE,
    input  wire logic       BUSY,
    output logic      [8:0] per_q,
    output int              loops
);
    initial per_q = 9'h000;
    task automatic step(input logic [7:0] m);
        per_q <= {1'b1, m};
        @(posedge CLK);
        per_q <= 9'h000;
        @(posedge CLK);
        @(posedge CLK);
    endtask
    task automatic phase(input logic with_end);
        step(8'h10);
        step(8'h08);
        if (with_end) begin
            step(8'h04);
        end
        step(8'h02);
    endtask
    task automatic run();
        loops = 0;
        step(8'h20);
        phase(1'b1);
        if (!RECYCLE_ENABLE) begin
            step(8'h01);
        end else begin
            phase(1'b1);
            // Bounded so a block that never ends cannot hang the model
            while (BUSY && loops < 13) begin
                phase(1'b0);
                loops++;
            end
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        CLK, ARST_N, LOAD_OPERANDS, DIVIDE_OPCODE, PERIOD6, REGISTER_CLOCK_STROBE;
    logic        PULSER_PERIOD0, PULSER_PERIOD7, PERIOD3, PERIOD4_MID_STROBE, PERIOD7;
    logic        PERIOD5_MID_STROBE, PERIOD5_END, PERIOD6_MID_STROBE, CARRY_FLAG_LATCH;
    logic        WAIT_FLAG, ONCE_FLAG, DIVISOR_LOOP_FLAG, DONE_LATCH, RECYCLE_ENABLE;
    logic        TWELVE_COUNT_N, BUSY;
    logic [11:0] DIVIDEND_HIGH_IN, DIVIDEND_LOW_IN, DIVISOR_IN, QUOTIENT_ACC, HIGH_ACC;
    logic [11:0] SAVE_ACC, MEMORY_DATA_HOLDING_REG;
    logic [8:0]  per;
    int          loops, num_errors, n_compared;
    assign {REGISTER_CLOCK_STROBE, PULSER_PERIOD0, PULSER_PERIOD7, PERIOD3, PERIOD4_MID_STROBE,
            PERIOD5_MID_STROBE, PERIOD5_END, PERIOD6_MID_STROBE, PERIOD7} = per;
    assign PERIOD6 = PERIOD6_MID_STROBE;
    hdsq_divider uut (.*);
    hdsq_pulser pulser (.CLK(CLK), .RECYCLE_ENABLE(RECYCLE_ENABLE), .BUSY(BUSY),
                        .per_q(per), .loops(loops));
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ld(input logic [11:0] h, input logic [11:0] l, input logic [11:0] d);
        DIVIDEND_HIGH_IN <= h;
        DIVIDEND_LOW_IN <= l;
        DIVISOR_IN <= d;
        LOAD_OPERANDS <= 1'b1;
        @(posedge CLK);
        LOAD_OPERANDS <= 1'b0;
        @(posedge CLK);
    endtask
    // A second load lands while busy and must change nothing
    task automatic go(input logic [11:0] h, input logic [11:0] l, input logic [11:0] d);
        ld(h, l, d);
        fork
            pulser.run();
            begin
                repeat (8) @(posedge CLK);
                ld(~h, ~l, d ^ 12'h0f0);
            end
        join
    endtask
    task automatic clear_flags();
        pulser.step(8'h40);
        pulser.step(8'h80);
        chk("wait once loop", 12'h000, 12'({WAIT_FLAG, ONCE_FLAG, DIVISOR_LOOP_FLAG}));
    endtask
    task automatic t_exit();
        go(12'h005, 12'h000, 12'h005);
        chk("exit flags", 12'h00d, 12'({RECYCLE_ENABLE, DONE_LATCH, CARRY_FLAG_LATCH, BUSY,
            WAIT_FLAG}));
        chk("save", 12'h005, SAVE_ACC);
        clear_flags();
        $display("test exit finished");
    endtask
    task automatic t_div(input logic [11:0] h, input logic [11:0] l, input logic [11:0] d);
        logic [23:0] n;
        n = {h, l};
        go(h, l, d);
        chk("quotient", 12'(n / d), QUOTIENT_ACC);
        chk("remainder", 12'(n % d), HIGH_ACC);
        chk("negated divisor", -d, MEMORY_DATA_HOLDING_REG);
        chk("iterations", 12'h00c, 12'(loops));
        chk("end flags", 12'h013, 12'({DONE_LATCH, BUSY, TWELVE_COUNT_N, ONCE_FLAG,
            DIVISOR_LOOP_FLAG}));
        clear_flags();
        $display("test divide %h%h by %h finished", h, l, d);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge CLK);
        num_errors++;
        $display("watchdog expired");
        summarize();
    end
    initial begin
        ARST_N = 1'b0;
        LOAD_OPERANDS = 1'b0;
        DIVIDE_OPCODE = 1'b1;
        {DIVIDEND_HIGH_IN, DIVIDEND_LOW_IN, DIVISOR_IN} = 36'h0;
        repeat (20) @(posedge CLK);
        ARST_N <= 1'b1;
        @(posedge CLK);
        chk("twelve count after reset", 12'h001, 12'(TWELVE_COUNT_N));
        t_exit();
        t_div(12'h000, 12'hfff, 12'h001);
        t_div(12'h123, 12'h456, 12'h7ff);
        t_div(12'h3ff, 12'hfff, 12'h400);
        t_div(12'h000, 12'h00a, 12'h00b);
        summarize();
    end
endmodule
`default_nettype wire
